// >>> shared/one_second_pkg.sv
/*
  Package for the one-second error count latch bank: register indices,
  field layout, counter widths and bus carrier types.
  Assumes a 32-bit AXI4-Lite register bus and a 100 MHz system clock.
*/
package one_second_pkg;

  // ==========================================================
  // Register map (printed offsets are indices; byte addr = 4 * index)
  localparam logic [7:0] idx_ebit_high = 8'h10;
  localparam logic [7:0] idx_ebit_low = 8'h11;
  localparam logic [7:0] idx_fas = 8'h12;
  localparam logic [7:0] idx_bpv_high = 8'h13;
  localparam logic [7:0] idx_bpv_low = 8'h14;
  localparam logic [7:0] idx_crc_high = 8'h15;
  localparam logic [7:0] idx_crc_low = 8'h16;
  localparam int addr_w = 10;
  localparam int word_shift = 2;

  // ==========================================================
  // Counter widths and reset values
  localparam int ebit_w = 10;
  localparam int fas_w = 8;
  localparam int bpv_w = 16;
  localparam int crc_w = 10;
  localparam int byte_w = 8;
  localparam logic [31:0] read_zero = 32'h0000_0000;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // ==========================================================
  // Timing: one second at 100 MHz
  localparam longint second_ns = 1000000000;
  localparam longint clk_period_ns = 10;
  localparam int second_cycles = int'(second_ns / clk_period_ns);

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ebit;
    logic fas;
    logic bpv;
    logic crc;
  } error_strobe_type;

  typedef struct packed {
    logic [ebit_w-1:0] ebit;
    logic [fas_w-1:0] fas;
    logic [bpv_w-1:0] bpv;
    logic [crc_w-1:0] crc;
  } count_set_type;

endpackage

// >>> rtl/second_tick_gen.sv
/*
  One-second tick divider: a one-cycle enable pulse every
  period_cycles clocks.
  Assumes a single clock and synchronous active-low reset.
*/
module second_tick_gen
  import one_second_pkg::*;
#(
  parameter int period_cycles = one_second_pkg::second_cycles
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Tick out
  output logic tick
);

  // ==========================================================
  // Divider
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    count_d = count_q + 32'h1;
    if (count_q == 32'(period_cycles - 1))
    begin
      count_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule // second_tick_gen

// >>> rtl/error_counter.sv
/*
  Running error counter with latch on tick, then restart from zero.
  An increment arriving in the tick cycle counts toward the new second.
  Assumes strobes are one cycle wide on clk.
*/
module error_counter
  import one_second_pkg::*;
#(
  parameter int width = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic inc,
  input wire logic tick,
  // Latched value
  output logic [width-1:0] latched
);

  // ==========================================================
  // Running and latched counts
  logic [width-1:0] run_q;
  logic [width-1:0] run_d;
  logic [width-1:0] lat_q;
  logic [width-1:0] lat_d;

  always_comb
  begin
    run_d = run_q;
    lat_d = lat_q;
    if (tick)
    begin
      lat_d = run_q;
      run_d = width'(inc);
    end
    else if (inc && run_q != {width{1'b1}})
    begin
      run_d = run_q + width'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      run_q <= '0;
      lat_q <= '0;
    end
    else
    begin
      run_q <= run_d;
      lat_q <= lat_d;
    end
  end

  assign latched = lat_q;

endmodule // error_counter

// >>> rtl/one_second_error_count_latches.sv
/*
  One-second error count latch bank: four running error counters
  sampled once per second into read-only registers on AXI4-Lite.
  Assumes increment strobes are one-cycle pulses from logic on clk.
*/
// Register access over AXI4-Lite is this design's own decision.
module one_second_error_count_latches
  import one_second_pkg::*;
// Overview of operation
// - 10-bit latched E-bit count, top bits at 10H, low byte at 11H.
// - Each second every running counter is copied to its latched register.
// - 8-bit errored alignment counter, one per bad FAS, read at 12H.
// - Line violation counter counts each violation up to FFFFH, then holds; bytes at 13H and 14H.
// - Violation counter is 16 bits, high byte at the lower offset.
// - 10-bit CRC-4 count, top bits at 15H, low byte at 16H.
#(
  parameter int period_cycles = one_second_pkg::second_cycles
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Error increment strobes
  input wire one_second_pkg::error_strobe_type strobes,
  // AXI4-Lite write address
  input wire logic [one_second_pkg::addr_w-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [one_second_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sampling tick seen by software
  output logic second_tick
);

  // ==========================================================
  // Tick and counters
  logic tick;
  count_set_type latched;

  second_tick_gen #(
    .period_cycles(period_cycles)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  error_counter #(
    .width(ebit_w)
  ) u_ebit (
    .clk(clk),
    .rst_n(rst_n),
    .inc(strobes.ebit),
    .tick(tick),
    .latched(latched.ebit)
  );

  error_counter #(
    .width(fas_w)
  ) u_fas (
    .clk(clk),
    .rst_n(rst_n),
    .inc(strobes.fas),
    .tick(tick),
    .latched(latched.fas)
  );

  error_counter #(
    .width(bpv_w)
  ) u_bpv (
    .clk(clk),
    .rst_n(rst_n),
    .inc(strobes.bpv),
    .tick(tick),
    .latched(latched.bpv)
  );

  error_counter #(
    .width(crc_w)
  ) u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .inc(strobes.crc),
    .tick(tick),
    .latched(latched.crc)
  );

  // ==========================================================
  // Read decode
  function automatic logic [32:0] read_word(
    input logic [addr_w-1:0] addr,
    input count_set_type c
  );
    logic [7:0] idx;
    logic [32:0] r;
    idx = 8'(addr >> word_shift);
    r = {1'b1, read_zero};
    if (addr[word_shift-1:0] == 2'h0)
    begin
      unique case (idx)
        idx_ebit_high: r = {1'b0, 30'h0, c.ebit[ebit_w-1:byte_w]};
        idx_ebit_low: r = {1'b0, 24'h0, c.ebit[byte_w-1:0]};
        idx_fas: r = {1'b0, 24'h0, c.fas};
        idx_bpv_high: r = {1'b0, 24'h0, c.bpv[bpv_w-1:byte_w]};
        idx_bpv_low: r = {1'b0, 24'h0, c.bpv[byte_w-1:0]};
        idx_crc_high: r = {1'b0, 30'h0, c.crc[crc_w-1:byte_w]};
        idx_crc_low: r = {1'b0, 24'h0, c.crc[byte_w-1:0]};
        default: r = {1'b1, read_zero};
      endcase
    end
    if (idx == idx_ebit_high || idx == idx_crc_high)
    begin
      r[31:2] = 30'h0;
    end
    return r;
  endfunction

  // ==========================================================
  // Read channel
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [32:0] rword;

  always_comb
  begin
    rword = read_word(s_axi_araddr, latched);
    arready_d = 1'b0;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !arready_q && !rvalid_q)
    begin
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rdata_d = rword[31:0];
      rresp_d = rword[32] ? resp_slverr : resp_okay;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= read_zero;
      rresp_q <= resp_okay;
    end
    else
    begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ==========================================================
  // Write channel: all registers read-only, writes answer SLVERR
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic aw_got_q;
  logic aw_got_d;
  logic w_got_q;
  logic w_got_d;
  logic bvalid_q;
  logic bvalid_d;

  always_comb
  begin
    awready_d = 1'b0;
    wready_d = 1'b0;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    bvalid_d = bvalid_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_got_d = 1'b1;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_got_d = 1'b1;
    end
    if (!bvalid_q && !aw_got_d && s_axi_awvalid && !awready_q)
    begin
      awready_d = 1'b1;
    end
    if (!bvalid_q && !w_got_d && s_axi_wvalid && !wready_q)
    begin
      wready_d = 1'b1;
    end
    if (aw_got_d && w_got_d && !bvalid_q)
    begin
      bvalid_d = 1'b1;
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      second_tick <= 1'b0;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      bvalid_q <= bvalid_d;
      second_tick <= tick;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = resp_slverr;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // one_second_error_count_latches

// >>> dv/one_second_error_count_latches_properties.sv
/*
  Checker for the one-second latch bank: bus handshakes, read layout
  and tick spacing, seen only at the top ports.
  Assumes the bind below hands on the tick period.
*/
module one_second_error_count_latches_properties
  import one_second_pkg::*;
#(
  parameter int period_cycles = 50
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strobes
  input wire one_second_pkg::error_strobe_type strobes,
  // Write channels
  input wire logic [one_second_pkg::addr_w-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [one_second_pkg::addr_w-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Tick
  input wire logic second_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [addr_w-1:0] addr_q, addr_d;
  logic [7:0] idx;
  logic armed_q, armed_d, mapped;
  int cnt_q, cnt_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Helper logic
  always_comb
  begin
    addr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : addr_q;
    cnt_d = second_tick ? 0 : cnt_q + 1;
    armed_d = armed_q | second_tick;
  end
  always_ff @(posedge clk)
  begin
    addr_q <= rst_n ? addr_d : '0;
    cnt_q <= rst_n ? cnt_d : 0;
    armed_q <= rst_n ? armed_d : 1'h0;
  end
  assign idx = addr_q[addr_w-1:2];
  assign mapped = addr_q[1:0] == 2'h0 && idx >= idx_ebit_high
    && idx <= idx_crc_low;
  // ==========================================================
  // Properties
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == resp_slverr;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write not refused");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_unused;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("upper bits set");
  property p_narrow;
    s_axi_rvalid && (idx == idx_ebit_high || idx == idx_crc_high)
      |-> s_axi_rdata[7:2] == 6'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("high field wide");
  property p_unmap;
    s_axi_rvalid && !mapped
      |-> s_axi_rresp == resp_slverr && s_axi_rdata == read_zero;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_map;
    s_axi_rvalid && mapped |-> s_axi_rresp == resp_okay;
  endproperty
  a_map: assert property (p_map) else $error("mapped read refused");
  property p_period;
    second_tick && armed_q |-> cnt_q == period_cycles - 1;
  endproperty
  a_period: assert property (p_period) else $error("tick spacing");
  c_tick: cover property (second_tick && armed_q);
  c_unmap: cover property (s_axi_rvalid && !mapped);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_high: cover property (s_axi_rvalid && s_axi_rdata[1:0] != 2'h0);
endmodule // one_second_error_count_latches_properties

bind one_second_error_count_latches
  one_second_error_count_latches_properties
  #(.period_cycles(period_cycles)) i_props (
  .clk(clk), .rst_n(rst_n), .strobes(strobes),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .second_tick(second_tick));

// >>> dv/one_second_error_count_latches_tb.sv
/*
  Testbench: bursts of error strobes per second, then register reads.
  Assumes a shortened second of per clock cycles.
*/
module one_second_error_count_latches_tb;
  import one_second_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int per = 700;
  logic clk = 1'h0, rst_n = 1'h0;
  error_strobe_type strobes = '0;
  logic [addr_w-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tick;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, wdata = '0, seed = 32'h53;
  int mismatches = 0, compares = 0;
  count_set_type model;
  one_second_error_count_latches #(.period_cycles(per)) i_dut (
    .clk(clk), .rst_n(rst_n), .strobes(strobes),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .second_tick(tick));
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] i,
    input count_set_type e);
    case (i)
      idx_ebit_high: return 32'(e.ebit[9:8]);
      idx_ebit_low: return 32'(e.ebit[7:0]);
      idx_fas: return 32'(e.fas);
      idx_bpv_high: return 32'(e.bpv[15:8]);
      idx_bpv_low: return 32'(e.bpv[7:0]);
      idx_crc_high: return 32'(e.crc[9:8]);
      idx_crc_low: return 32'(e.crc[7:0]);
      default: return read_zero;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [7:0] i, input logic [1:0] sub,
    output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    seed = xs(seed);
    araddr <= {i, sub};
    arvalid <= 1'h1;
    rready <= seed[0];
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    // Late rready on some reads so rvalid must wait
    if (rready !== 1'h1)
    begin
      @(posedge clk);
      rready <= 1'h1;
    end
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] i);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge clk);
    awaddr <= {i, 2'h0};
    wdata <= seed;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= seed[1];
    do
    begin
      @(posedge clk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
      ad |= awready === 1'h1;
      wd |= wready === 1'h1;
    end while (!(ad && wd));
    // Late bready on some writes so bvalid must wait
    if (bready !== 1'h1)
    begin
      @(posedge clk);
      bready <= 1'h1;
    end
    do @(posedge clk); while (bvalid !== 1'h1);
    check(32'(bresp), 32'(resp_slverr));
    bready <= 1'h0;
  endtask
  task automatic sync();
    do @(posedge clk); while (tick !== 1'h1);
  endtask
  task automatic burst(input int mode);
    error_strobe_type s;
    model = '0;
    sync();
    for (int n = 0; n < per - 60; n++)
    begin
      seed = xs(seed);
      s = error_strobe_type'(mode == 1 ? 4'hf : mode == 2 ? 4'h0 : seed[3:0]);
      strobes <= s;
      if (s.ebit && model.ebit != '1) model.ebit++;
      if (s.fas && model.fas != '1) model.fas++;
      if (s.bpv && model.bpv != '1) model.bpv++;
      if (s.crc && model.crc != '1) model.crc++;
      @(posedge clk);
    end
    strobes <= '0;
  endtask
  task automatic chk_all(input count_set_type e);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = idx_ebit_high; i <= idx_crc_low; i++)
    begin
      rd(8'(i), 2'h0, d, r);
      check(d, exp_rd(8'(i), e));
      check(32'(r), 32'(resp_okay));
    end
    wr(idx_fas);
    rd(idx_fas, 2'h0, d, r);
    check(d, exp_rd(idx_fas, e));
    rd(8'h17, 2'h0, d, r);
    check(d, read_zero);
    check(32'(r), 32'(resp_slverr));
    rd(idx_bpv_low, 2'h1, d, r);
    check(32'(r), 32'(resp_slverr));
    check(d, read_zero);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    for (int m = 1; m <= 5; m++)
    begin
      burst(m);
      sync();
      chk_all(model);
      sync();
      chk_all('0);
    end
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule // one_second_error_count_latches_tb
